// ===== rtl/usbpp_pkg.sv
// Purpose: constants and carrier types for the descriptor mapper
// Assumes: 32-bit classic Wishbone, byte addresses, 16 endpoints
// Notes: descriptor word n sits at byte 4n, control words from 0x100
package usbpp_pkg;

   localparam int          EP_NUM    = 16;
   localparam int          DESC_NUM  = 64;
   localparam int          ADR_W     = 9;

   localparam logic [8:0]  ADR_CFG   = 9'h100;
   localparam logic [8:0]  ADR_XFER  = 9'h104;
   localparam logic [8:0]  ADR_STAT  = 9'h108;
   localparam logic [8:0]  ADR_ERR   = 9'h10C;

   // descriptor status byte fields
   localparam int          OWN_BIT   = 7;
   localparam int          DTS_BIT   = 6;
   localparam int          TCE_BIT   = 3;
   localparam int          STALL_BIT = 2;

   // configuration word fields
   localparam int          CFG_EN_BIT  = 2;
   localparam int          CFG_RST_BIT = 3;

   // transfer status word fields
   localparam int          XF_ODD_BIT = 1;
   localparam int          XF_DIR_BIT = 2;
   localparam int          XF_EP_LO   = 3;

   // status flag word fields
   localparam int          STAT_ERR_BIT = 1;
   localparam int          STAT_TRN_BIT = 3;
   localparam logic [7:0]  STAT_MASK    = 8'h7F;

   localparam logic [7:0]  FLAG_RST  = 8'h00;
   localparam logic [31:0] PTR_RST   = 32'h0000_0000;

   typedef enum logic [1:0] {
      PP_NONE,
      PP_EP0_OUT,
      PP_ALL,
      PP_ALL_BUT_EP0
   } usbpp_mode_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [8:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } usbpp_wb_req_t;

   typedef struct packed {
      logic [3:0]  ep;
      logic        dirIn;
   } usbpp_tok_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  ep;
      logic        dirIn;
      logic [3:0]  pid;
      logic [9:0]  count;
   } usbpp_done_t;

   typedef struct packed {
      logic [5:0]  idx;
      logic        own;
      logic        toggleCheck;
      logic        toggleValue;
      logic        stall;
      logic [9:0]  count;
      logic [15:0] addr;
   } usbpp_desc_t;

endpackage : usbpp_pkg

// ===== rtl/usbpp_mapper.sv
// Purpose: descriptor selection, ping-pong pointers and interrupt funnel
// Assumes: engine signals are on sys_clk; engine done is a one-cycle pulse
// Notes: descriptor memory is never reset, its contents start undefined

module usbpp_mapper
(
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire usbpp_pkg::usbpp_wb_req_t wbReq,
   output logic [31:0]                 wbDatOut,
   output logic                        wbAck,
   input  wire usbpp_pkg::usbpp_tok_t  engTok,
   input  wire usbpp_pkg::usbpp_done_t engDone,
   input  wire logic [7:0]             engStatEvent,
   input  wire logic [7:0]             engErrEvent,
   output usbpp_pkg::usbpp_desc_t      engDesc,
   output logic                        usbRequestFlag
);
   import usbpp_pkg::*;

   typedef struct packed {
      usbpp_mode_t mode;
      logic        enable;
      logic        ptrRst;
      logic [31:0] ptr;
      logic [3:0]  xferEp;
      logic        xferIn;
      logic        xferOdd;
      logic [7:0]  statFlag;
      logic [7:0]  statEn;
      logic [7:0]  errFlag;
      logic [7:0]  errEn;
      logic        reqFlag;
      logic        ack;
      logic [31:0] rdata;
   } usbpp_state_t;

   usbpp_state_t s;
   usbpp_state_t next_s;

   logic [31:0]  descMem [DESC_NUM];
   logic         busAcc;
   logic         busWr;
   logic         descWr;
   logic [5:0]   doneIdx;
   logic [5:0]   tokIdx;
   logic         donePp;
   logic         doneOdd;

   // true when this endpoint and direction is double-buffered in mode
   function automatic logic isPp(usbpp_mode_t m, logic [3:0] ep,
                                 logic dirIn);
      logic r;
      r = 1'b0;
      unique case (m)
         PP_NONE:        r = 1'b0;
         PP_EP0_OUT:     r = (ep == 4'h0) && !dirIn;
         PP_ALL:         r = 1'b1;
         PP_ALL_BUT_EP0: r = (ep != 4'h0);
      endcase
      return r;
   endfunction : isPp

   function automatic logic [5:0] descIndex(usbpp_mode_t m,
                                            logic [3:0] ep,
                                            logic dirIn,
                                            logic odd);
      logic [5:0] e2;
      logic [5:0] e4;
      logic [5:0] r;
      e2 = {1'b0, ep, 1'b0};
      e4 = {ep, 2'b00};
      r  = 6'h00;
      unique case (m)
         PP_NONE:
            r = e2 | {5'h00, dirIn};
         PP_EP0_OUT:
            if (ep == 4'h0)
            begin
               r = dirIn ? 6'h02 : {5'h00, odd};
            end
            else
            begin
               r = e2 + 6'h01 + {5'h00, dirIn};
            end
         PP_ALL:
            r = e4 | {4'h0, dirIn, odd};
         PP_ALL_BUT_EP0:
            if (ep == 4'h0)
            begin
               r = {5'h00, dirIn};
            end
            else
            begin
               // wraps correctly for ep >= 1: highest slot is 61
               r = e4 - 6'h02 + {4'h0, dirIn, odd};
            end
      endcase
      return r;
   endfunction : descIndex

   assign busAcc = wbReq.cyc & wbReq.stb & ~s.ack;
   assign busWr  = busAcc & wbReq.we;
   assign descWr = busWr & ~wbReq.adr[8];

   // a pointer is ignored where the endpoint has a single descriptor
   assign donePp  = isPp(s.mode, engDone.ep, engDone.dirIn);
   assign doneOdd = donePp & s.ptr[{engDone.ep, engDone.dirIn}];
   assign doneIdx = descIndex(s.mode, engDone.ep, engDone.dirIn, doneOdd);

   always_comb
   begin
      logic       tokOdd;
      tokOdd = isPp(s.mode, engTok.ep, engTok.dirIn)
               & s.ptr[{engTok.ep, engTok.dirIn}];
      tokIdx = descIndex(s.mode, engTok.ep, engTok.dirIn, tokOdd);
   end

   always_comb
   begin
      next_s       = s;
      next_s.ack   = busAcc;
      next_s.rdata = 32'h0000_0000;

      if (busAcc && !wbReq.we)
      begin
         if (!wbReq.adr[8])
         begin
            next_s.rdata = descMem[wbReq.adr[7:2]];
         end
         else
         begin
            unique case (wbReq.adr)
               ADR_CFG:
                  next_s.rdata = {28'h000_0000, s.ptrRst, s.enable, s.mode};
               ADR_XFER:
                  next_s.rdata = {25'h000_0000, s.xferEp, s.xferIn,
                                  s.xferOdd, 1'b0};
               ADR_STAT:
                  next_s.rdata = {16'h0000, s.statEn, s.statFlag};
               ADR_ERR:
                  next_s.rdata = {16'h0000, s.errEn, s.errFlag};
               default:
                  next_s.rdata = 32'h0000_0000;
            endcase
         end
      end

      if (busWr && wbReq.adr == ADR_CFG && wbReq.sel[0])
      begin
         next_s.mode   = usbpp_mode_t'(wbReq.dat[1:0]);
         next_s.enable = wbReq.dat[CFG_EN_BIT];
         next_s.ptrRst = wbReq.dat[CFG_RST_BIT];
      end

      // software writes 0 to clear and 1 to set, except status bit 7 (masked) and summary bit 1; hardware events win below
      if (busWr && wbReq.adr == ADR_STAT)
      begin
         if (wbReq.sel[0])
         begin
            next_s.statFlag = wbReq.dat[7:0] & STAT_MASK;
         end
         if (wbReq.sel[1])
         begin
            next_s.statEn = wbReq.dat[15:8] & STAT_MASK;
         end
      end
      if (busWr && wbReq.adr == ADR_ERR)
      begin
         if (wbReq.sel[0])
         begin
            next_s.errFlag = wbReq.dat[7:0];
         end
         if (wbReq.sel[1])
         begin
            next_s.errEn = wbReq.dat[15:8];
         end
      end

      next_s.errFlag  = next_s.errFlag | engErrEvent;
      next_s.statFlag = next_s.statFlag | (engStatEvent & STAT_MASK);

      if (engDone.valid)
      begin
         if (donePp)
         begin
            next_s.ptr[{engDone.ep, engDone.dirIn}] = ~doneOdd;
         end
         next_s.xferEp  = engDone.ep;
         next_s.xferIn  = engDone.dirIn;
         next_s.xferOdd = doneOdd;
         next_s.statFlag[STAT_TRN_BIT] = 1'b1;
      end

      // error summary follows the enabled second-level flags only
      next_s.statFlag[STAT_ERR_BIT] =
         |(next_s.errFlag & next_s.errEn);
      next_s.reqFlag = |(next_s.statFlag & next_s.statEn);

      // a disabled module holds even, so enabling always starts even
      if (!next_s.enable || next_s.ptrRst)
      begin
         next_s.ptr = PTR_RST;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s.mode     <= PP_NONE;
         s.enable   <= 1'b0;
         s.ptrRst   <= 1'b0;
         s.ptr      <= PTR_RST;
         s.xferEp   <= 4'h0;
         s.xferIn   <= 1'b0;
         s.xferOdd  <= 1'b0;
         s.statFlag <= FLAG_RST;
         s.statEn   <= FLAG_RST;
         s.errFlag  <= FLAG_RST;
         s.errEn    <= FLAG_RST;
         s.reqFlag  <= 1'b0;
         s.ack      <= 1'b0;
         s.rdata    <= 32'h0000_0000;
      end
      else
      begin
         s <= next_s;
      end
   end

   // table memory has no reset; engine write follows bus write so it wins
   always_ff @(posedge sys_clk)
   begin
      logic [31:0] rd;
      if (descWr)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wbReq.sel[b])
            begin
               descMem[wbReq.adr[7:2]][b*8 +: 8] <= wbReq.dat[b*8 +: 8];
            end
         end
      end
      if (engDone.valid)
      begin
         // hand back to software: owner clear, bit 6 left as software set it
         descMem[doneIdx][15:0] <= {engDone.count[7:0], 1'b0,
                                    descMem[doneIdx][DTS_BIT],
                                    engDone.pid,
                                    engDone.count[9:8]};
      end
      rd                  = descMem[tokIdx];
      engDesc.idx         <= tokIdx;
      engDesc.own         <= rd[OWN_BIT];
      engDesc.toggleCheck <= rd[TCE_BIT];
      engDesc.toggleValue <= rd[TCE_BIT] & rd[DTS_BIT];
      engDesc.stall       <= rd[STALL_BIT];
      engDesc.count       <= {rd[1:0], rd[15:8]};
      engDesc.addr        <= rd[31:16];
   end

   assign wbDatOut       = s.rdata;
   assign wbAck          = s.ack;
   assign usbRequestFlag = s.reqFlag;

endmodule : usbpp_mapper

// ===== dv/usbpp_mapper_assertions.sv
// Purpose: bus, lookup and write-back properties of the descriptor mapper
// Assumes: mode is followed from config writes seen on the bus
// Notes: bound to every usbpp_mapper instance
module usbpp_mapper_chk
(
   input wire logic                    sys_clk,
   input wire logic                    sys_rst,
   input wire usbpp_pkg::usbpp_wb_req_t wbReq,
   input wire logic [31:0]             wbDatOut,
   input wire logic                    wbAck,
   input wire usbpp_pkg::usbpp_tok_t   engTok,
   input wire usbpp_pkg::usbpp_done_t  engDone,
   input wire logic [7:0]              engStatEvent,
   input wire logic [7:0]              engErrEvent,
   input wire usbpp_pkg::usbpp_desc_t  engDesc,
   input wire logic                    usbRequestFlag
);
   import usbpp_pkg::*;
   usbpp_mode_t mode;
   usbpp_mode_t next_mode;
   always_comb
   begin
      next_mode = mode;
      // follow the edge at which the mapper takes the write, not the ack edge
      if (wbReq.cyc && wbReq.stb && wbReq.we && !wbAck && wbReq.adr == ADR_CFG && wbReq.sel[0])
         next_mode = usbpp_mode_t'(wbReq.dat[1:0]);
   end
   always_ff @(posedge sys_clk)
      mode <= sys_rst ? PP_NONE : next_mode;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_taken;
      wbReq.cyc && wbReq.stb && !wbAck;
   endsequence
   // write-back only checked where the pointer cannot move the lookup away
   sequence s_done_fixed;
      engDone.valid && mode == PP_NONE && engTok.ep == engDone.ep && engTok.dirIn == engDone.dirIn;
   endsequence
   a_ack_next: assert property (s_taken |=> wbAck) else $error("ack missing");
   a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack too long");
   a_ack_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb)) else $error("ack unasked");
   a_dat_idle: assert property (!wbAck |-> wbDatOut == 32'h0000_0000) else $error("data not idle");
   a_toggle_ignored: assert property (!engDesc.toggleCheck |-> !engDesc.toggleValue)
      else $error("toggle value leaks");
   a_idx_none: assert property (mode == PP_NONE |=> engDesc.idx == {1'b0, $past(engTok.ep), $past(engTok.dirIn)})
      else $error("index in plain mode");
   a_idx_all: assert property (mode == PP_ALL |=> engDesc.idx[5:1] == {$past(engTok.ep), $past(engTok.dirIn)})
      else $error("index in full mode");
   a_done_back: assert property (s_done_fixed |-> ##2 (!engDesc.own && engDesc.count == $past(engDone.count, 2)))
      else $error("write-back missing");
endmodule : usbpp_mapper_chk

bind usbpp_mapper usbpp_mapper_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbReq(wbReq),
   .wbDatOut(wbDatOut), .wbAck(wbAck), .engTok(engTok), .engDone(engDone), .engStatEvent(engStatEvent),
   .engErrEvent(engErrEvent), .engDesc(engDesc), .usbRequestFlag(usbRequestFlag));

// ===== dv/usbpp_engine_model.sv
// Purpose: protocol engine stand-in: lookups, completions, events
// Assumes: completions always use the descriptor currently looked up
// Notes: every signal changes right after a rising edge
module usbpp_engine_model
(
   input  wire logic            sys_clk,
   output usbpp_pkg::usbpp_tok_t  engTok,
   output usbpp_pkg::usbpp_done_t engDone,
   output logic [7:0]           engStatEvent,
   output logic [7:0]           engErrEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   import usbpp_pkg::*;
   initial
   begin
      engTok       = '0;
      engDone      = '0;
      engStatEvent = 8'h00;
      engErrEvent  = 8'h00;
   end
   task automatic look(input logic [3:0] ep, input logic dirIn);
      @(posedge sys_clk);
      engTok <= '{ep: ep, dirIn: dirIn};
      repeat (2) @(posedge sys_clk);
   endtask : look
   // completion hands the descriptor back, one-cycle pulse
   task automatic finish(input logic [3:0] pid, input logic [9:0] count);
      @(posedge sys_clk);
      engDone <= '{1'b1, engTok.ep, engTok.dirIn, pid, count};
      @(posedge sys_clk);
      engDone.valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : finish
   task automatic raise(input logic [7:0] st, input logic [7:0] er);
      @(posedge sys_clk);
      engStatEvent <= st;
      engErrEvent  <= er;
      @(posedge sys_clk);
      engStatEvent <= 8'h00;
      engErrEvent  <= 8'h00;
   endtask : raise
endmodule : usbpp_engine_model

// ===== dv/usbpp_tb.sv
// Purpose: directed test of mapping, ping-pong and interrupt funnel
// Assumes: engine model drives the engine side
// Notes: expectations come from the mapping rules, not the design
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import usbpp_pkg::*;
   logic          sys_clk = 1'b0;
   logic          sys_rst = 1'b1;
   usbpp_wb_req_t wbReq   = '0;
   logic [31:0]   wbDatOut;
   logic          wbAck;
   usbpp_tok_t    engTok;
   usbpp_done_t   engDone;
   logic [7:0]    engStatEvent;
   logic [7:0]    engErrEvent;
   usbpp_desc_t   engDesc;
   logic          usbRequestFlag;
   logic [31:0]   rd;
   int            n_fail = 0;
   int            comparisons = 0;
   int            eps[3] = '{0, 1, 15};
   usbpp_mapper dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbDatOut(wbDatOut),
      .wbAck(wbAck), .engTok(engTok), .engDone(engDone), .engStatEvent(engStatEvent),
      .engErrEvent(engErrEvent), .engDesc(engDesc), .usbRequestFlag(usbRequestFlag));
   usbpp_engine_model eng_u (.sys_clk(sys_clk), .engTok(engTok), .engDone(engDone),
      .engStatEvent(engStatEvent), .engErrEvent(engErrEvent));
   task automatic wrap_up;
      $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic bus(input logic we, input logic [8:0] adr, input logic [31:0] wdat);
      int i;
      i = 0;
      @(posedge sys_clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wdat};
      do
      begin
         @(posedge sys_clk);
         i++;
      end
      while (wbAck !== 1'b1 && i < 20);
      rd = wbDatOut;
      wbReq <= '0;
      if (wbAck !== 1'b1)
      begin
         n_fail++;
         wrap_up();
      end
   endtask : bus
   function automatic logic [5:0] exp_idx(input int m, input int ep, input int d, input int odd);
      case (m)
         0: return 6'(2 * ep + d);
         1: return (ep == 0) ? 6'(d ? 2 : odd) : 6'(2 * ep + 1 + d);
         2: return 6'(4 * ep + 2 * d + odd);
         default: return (ep == 0) ? 6'(d) : 6'(4 * ep - 2 + 2 * d + odd);
      endcase
   endfunction : exp_idx
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      bus(1'b0, ADR_XFER, 32'h0000_0000);
      check(rd, 32'h0000_0000, "xfer");
      bus(1'b0, ADR_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0000, "flags");
      bus(1'b1, 9'h11C, 32'hFFFF_FFFF);
      bus(1'b0, 9'h11C, 32'h0000_0000);
      check(rd, 32'h0000_0000, "unmapped");
      bus(1'b1, 9'h0FC, 32'hA5C3_5A03);
      bus(1'b0, 9'h0FC, 32'h0000_0000);
      check(rd, 32'hA5C3_5A03, "slot 63");
      $display("test registers done");
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, ADR_CFG, 32'(m) | 32'h0000_0004);
         foreach (eps[k])
            for (int d = 0; d < 2; d++)
            begin
               eng_u.look(4'(eps[k]), d[0]);
               check(32'(engDesc.idx), 32'(exp_idx(m, eps[k], d, 0)), "index");
            end
      end
      $display("test mapping done");
      bus(1'b1, ADR_STAT, 32'h0000_0800);
      bus(1'b1, 9'h008, 32'h3412_40C0);
      eng_u.look(4'h1, 1'b0);
      check(32'(engDesc.idx), 32'h0000_0002, "even");
      check(32'({engDesc.own, engDesc.toggleCheck, engDesc.toggleValue, engDesc.stall}), 32'h0000_0008, "own");
      check({engDesc.addr, 6'h00, engDesc.count}, 32'h3412_0040, "count");
      eng_u.finish(4'hD, 10'h2A7);
      check(32'(usbRequestFlag), 32'h0000_0001, "request");
      check(32'(engDesc.idx), 32'h0000_0003, "odd");
      bus(1'b0, ADR_XFER, 32'h0000_0000);
      check(rd, 32'h0000_0008, "parity even");
      bus(1'b0, 9'h008, 32'h0000_0000);
      check(rd, 32'h3412_A776, "write-back");
      eng_u.finish(4'h1, 10'h005);
      check(32'(engDesc.idx), 32'h0000_0002, "back even");
      bus(1'b0, ADR_XFER, 32'h0000_0000);
      check(rd, 32'h0000_000A, "parity odd");
      eng_u.finish(4'h1, 10'h005);
      bus(1'b1, ADR_CFG, 32'h0000_000E);
      eng_u.look(4'h1, 1'b0);
      check(32'(engDesc.idx), 32'h0000_0004, "pointer reset");
      bus(1'b1, ADR_CFG, 32'h0000_0004);
      eng_u.look(4'h1, 1'b0);
      eng_u.finish(4'h9, 10'h011);
      check(32'({engDesc.own, engDesc.count}), 32'h0000_0011, "plain write-back");
      $display("test ping-pong done");
      bus(1'b1, ADR_STAT, 32'h0000_0800);
      bus(1'b1, ADR_ERR, 32'h0000_0100);
      eng_u.raise(8'h40, 8'h01);
      bus(1'b0, ADR_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0842, "summary");
      check(32'(usbRequestFlag), 32'h0000_0000, "masked");
      bus(1'b1, ADR_STAT, 32'h0000_0200);
      bus(1'b0, ADR_STAT, 32'h0000_0000);
      check(32'(usbRequestFlag), 32'h0000_0001, "funnel");
      $display("test interrupts done");
      wrap_up();
   end
endmodule : testbench
